/* hw/tw_pkg.sv */
package tw_pkg;

   // Master bit timing: one quarter of a standard-rate bus clock period
   localparam int          CLK_NS   = 40;
   localparam int          QTR_NS   = 2500;
   localparam int          QTR_CYC  = (QTR_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [5:0]  QTR_LOAD = 6'(QTR_CYC - 1);

   localparam logic [7:0]  A_CON    = 8'h00;
   localparam logic [7:0]  A_STAT   = 8'h04;
   localparam logic [7:0]  A_TX     = 8'h08;
   localparam logic [7:0]  A_RX     = 8'h0C;
   localparam logic [7:0]  A_OWN    = 8'h10;

   localparam logic [15:0] CON_RST  = 16'h1000;
   localparam logic [15:0] STAT_RST = 16'h0000;
   localparam logic [9:0]  OWN_RST  = 10'h000;
   localparam logic [4:0]  WIDE_HDR = 5'h1E;
   localparam logic [3:0]  ACK_SLOT = 4'h8;

   typedef struct packed {
      logic module_on;
      logic rsv14;
      logic halt_in_idle;
      logic clock_release;
      logic accept_all_addresses;
      logic wide_address_select;
      logic slew_limit_off;
      logic alt_input_thresholds;
      logic broadcast_enable;
      logic stretch_enable;
      logic ack_value;
      logic ack_sequence_go;
      logic master_receive_go;
      logic stop_go;
      logic restart_go;
      logic start_go;
   } tw_con_t;

   typedef struct packed {
      logic       slave_ack_seen;
      logic       master_tx_active;
      logic [2:0] rsv;
      logic       collision_flag;
      logic       broadcast_seen;
      logic       wide_address_matched;
      logic       tx_write_clash;
      logic       rx_overflow;
      logic       data_not_addr;
      logic       stop_seen;
      logic       start_seen;
      logic       read_not_write;
      logic       rx_full;
      logic       tx_full;
   } tw_stat_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
   } tw_av_req_t;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } tw_av_rsp_t;

   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } tw_pin_t;

   typedef struct packed {
      logic pins_owned;
      logic slew_limit_off;
      logic alt_input_thresholds;
   } tw_pad_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } tw_line_t;

   typedef enum logic [2:0] {
      M_IDLE    = 3'h0,
      M_START   = 3'h1,
      M_TX      = 3'h3,
      M_ACK     = 3'h2,
      M_RX      = 3'h6,
      M_STOP    = 3'h7,
      M_RESTART = 3'h5
   } tw_m_st_t;

   typedef enum logic [2:0] {
      S_OFF   = 3'h0,
      S_ADDR  = 3'h1,
      S_ADDR2 = 3'h3,
      S_RX    = 3'h2,
      S_TX    = 3'h6
   } tw_s_md_t;

endpackage

/* hw/tw_line_mon.sv */
`timescale 1ns/1ns
module tw_line_mon (
   input  wire logic           i_clk,
   input  wire logic           i_nrst,
   input  wire logic           i_scl,
   input  wire logic           i_sda,
   output tw_pkg::tw_line_t    o_line
);
   import tw_pkg::*;

   // Bit 1 is the clock line, bit 0 the data line
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
      tw_line_t   ln;
   } tw_mon_t;

   tw_mon_t q;
   tw_mon_t d;

   always_comb begin
      d             = q;
      d.s1          = {i_scl, i_sda};
      d.s2          = q.s1;
      d.s3          = q.s2;
      d.ln.scl      = q.s2[1];
      d.ln.sda      = q.s2[0];
      d.ln.scl_rise = q.s2[1] & ~q.s3[1];
      d.ln.scl_fall = ~q.s2[1] & q.s3[1];
      // Data edges while the clock stays high mark start and stop
      d.ln.start    = q.s2[1] & q.s3[1] & q.s3[0] & ~q.s2[0];
      d.ln.stop     = q.s2[1] & q.s3[1] & ~q.s3[0] & q.s2[0];
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q        <= '0;
         q.s1     <= 2'h3;
         q.s2     <= 2'h3;
         q.s3     <= 2'h3;
         q.ln.scl <= 1'b1;
         q.ln.sda <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign o_line = q.ln;

endmodule

/* hw/tw_ctrl.sv */
`timescale 1ns/1ns
module tw_ctrl (
   input  wire logic           i_clk,
   input  wire logic           i_nrst,
   input  wire logic           i_idle_req,
   input  wire logic           i_scl,
   input  wire logic           i_sda,
   input  tw_pkg::tw_av_req_t  i_av,
   output tw_pkg::tw_av_rsp_t  o_av,
   output tw_pkg::tw_pin_t     o_pin,
   output tw_pkg::tw_pad_t     o_pad,
   output logic                o_master_event,
   output logic                o_slave_event
);
   import tw_pkg::*;

   typedef struct packed {
      tw_con_t    con;
      tw_stat_t   stat;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [9:0] own;
      tw_av_rsp_t av;
      tw_pin_t    pin;
      tw_pad_t    pad;
      tw_m_st_t   m_st;
      logic [1:0] m_ph;
      logic [3:0] m_bit;
      logic [7:0] m_sh;
      logic [5:0] m_div;
      logic       m_own;
      logic       m_scl_low;
      logic       m_sda_low;
      tw_s_md_t   s_md;
      logic [3:0] s_bit;
      logic [7:0] s_sh;
      logic       s_sda_low;
      logic       m_evt;
      logic       s_evt;
   } tw_st_t;

   tw_st_t   q;
   tw_st_t   d;
   tw_line_t ln;

   tw_line_mon u_mon (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_scl  (i_scl),
      .i_sda  (i_sda),
      .o_line (ln)
   );

   always_comb begin
      logic     req, take, fin, run, busy, adv, msda, gc, hit, ssda;
      tw_con_t  wc;
      tw_stat_t ws;
      req  = i_av.read | i_av.write;
      take = req & q.av.waitrequest;
      fin  = req & ~q.av.waitrequest;
      run  = q.con.module_on & ~(q.con.halt_in_idle & i_idle_req);
      busy = (q.m_st != M_IDLE) | q.stat.tx_full;
      adv  = 1'b0;
      msda = 1'b0;
      gc   = 1'b0;
      hit  = 1'b0;
      ssda = 1'b0;
      wc   = i_av.writedata[15:0];
      ws   = i_av.writedata[15:0];
      d       = q;
      d.m_evt = 1'b0;
      d.s_evt = 1'b0;

      // Bus slave: request taken while waitrequest is high, answered one cycle later
      d.av.waitrequest = ~take;
      if (take && i_av.read) begin
         unique case (i_av.address)
            A_CON:   d.av.readdata = 32'(q.con);
            A_STAT:  d.av.readdata = 32'(q.stat);
            A_TX:    d.av.readdata = 32'(q.tx);
            A_RX:    d.av.readdata = 32'(q.rx);
            A_OWN:   d.av.readdata = 32'(q.own);
            default: d.av.readdata = 32'h0000_0000;
         endcase
      end
      if (fin && i_av.read && i_av.address == A_RX) d.stat.rx_full = 1'b0;
      if (fin && i_av.write) begin
         unique case (i_av.address)
            A_CON: begin
               d.con       = wc;
               d.con.rsv14 = 1'b0;
               if (!q.con.stretch_enable) d.con.clock_release = q.con.clock_release | wc.clock_release;
            end
            A_STAT: begin
               // Sticky flags clear only where software writes a zero
               d.stat.collision_flag = q.stat.collision_flag & ws.collision_flag;
               d.stat.tx_write_clash = q.stat.tx_write_clash & ws.tx_write_clash;
               d.stat.rx_overflow    = q.stat.rx_overflow & ws.rx_overflow;
               d.stat.stop_seen      = q.stat.stop_seen & ws.stop_seen;
               d.stat.start_seen     = q.stat.start_seen & ws.start_seen;
            end
            A_TX: begin
               if (busy) d.stat.tx_write_clash = 1'b1;
               else begin
                  d.tx                 = i_av.writedata[7:0];
                  d.stat.tx_full       = 1'b1;
                  d.stat.data_not_addr = 1'b1;
                  if (q.m_own && q.con.module_on) begin
                     d.m_st                  = M_TX;
                     d.m_sh                  = i_av.writedata[7:0];
                     d.m_ph                  = 2'h0;
                     d.m_bit                 = 4'h0;
                     d.m_div                 = QTR_LOAD;
                     d.stat.master_tx_active = 1'b1;
                  end
               end
            end
            A_OWN:   d.own = i_av.writedata[9:0];
            default: d.own = q.own;
         endcase
      end

      if (!q.con.module_on) begin
         d.m_st      = M_IDLE;
         d.m_own     = 1'b0;
         d.m_scl_low = 1'b0;
         d.m_sda_low = 1'b0;
         d.s_md      = S_OFF;
         d.s_sda_low = 1'b0;
      end else if (run) begin
         // Master dispatch from software go bits
         if (q.m_st == M_IDLE && d.m_st == M_IDLE) begin
            d.m_ph  = 2'h0;
            d.m_bit = 4'h0;
            d.m_div = QTR_LOAD;
            if (q.con.start_go) d.m_st = M_START;
            else if (q.con.restart_go) d.m_st = M_RESTART;
            else if (q.con.stop_go) d.m_st = M_STOP;
            else if (q.con.master_receive_go) d.m_st = M_RX;
            else if (q.con.ack_sequence_go) d.m_st = M_ACK;
         end else if (q.m_st != M_IDLE) begin
            if (q.m_div == 6'h00) begin
               d.m_div = QTR_LOAD;
               // Hold the high phase until the clock line is really high
               adv     = ~(q.m_ph == 2'h2 && !ln.scl);
            end else begin
               d.m_div = q.m_div - 6'h01;
            end
         end
         unique case (q.m_st)
            M_STOP:    msda = 1'b1;
            M_TX:      msda = (q.m_bit < ACK_SLOT) & ~q.m_sh[7];
            M_ACK:     msda = ~q.con.ack_value;
            default:   msda = 1'b0;
         endcase
         if (adv) begin
            d.m_ph = q.m_ph + 2'h1;
            unique case (q.m_ph)
               2'h0: begin
                  d.m_scl_low = (q.m_st != M_START);
                  d.m_sda_low = msda;
               end
               2'h1: d.m_scl_low = 1'b0;
               2'h2: begin
                  if (q.m_st == M_START || q.m_st == M_RESTART) d.m_sda_low = 1'b1;
                  else if (q.m_st == M_STOP) d.m_sda_low = 1'b0;
                  else if (q.m_st == M_RX) d.m_sh = {q.m_sh[6:0], ln.sda};
                  else if (q.m_st == M_TX && q.m_bit == ACK_SLOT) d.stat.slave_ack_seen = ln.sda;
                  if (q.m_st == M_TX && q.m_bit < ACK_SLOT && q.m_sh[7] && !ln.sda) begin
                     d.stat.collision_flag   = 1'b1;
                     d.stat.master_tx_active = 1'b0;
                     d.m_evt                 = 1'b1;
                     d.m_st                  = M_IDLE;
                     d.m_own                 = 1'b0;
                     d.m_scl_low             = 1'b0;
                     d.m_sda_low             = 1'b0;
                     // All five go bits abandon with the lost sequence
                     d.con[4:0]              = 5'h00;
                  end
               end
               default: begin
                  d.m_scl_low = (q.m_st != M_STOP);
                  d.m_bit     = q.m_bit + 4'h1;
                  d.m_st      = M_IDLE;
                  d.m_evt     = 1'b1;
                  unique case (q.m_st)
                     M_START: begin
                        d.con.start_go = 1'b0;
                        d.m_own        = 1'b1;
                     end
                     M_RESTART: d.con.restart_go = 1'b0;
                     M_STOP: begin
                        d.con.stop_go = 1'b0;
                        d.m_own       = 1'b0;
                     end
                     M_ACK: d.con.ack_sequence_go = 1'b0;
                     M_TX: begin
                        d.m_sh = {q.m_sh[6:0], 1'b0};
                        if (q.m_bit == ACK_SLOT) begin
                           d.stat.master_tx_active = 1'b0;
                           d.stat.tx_full          = 1'b0;
                        end else begin
                           d.m_st  = M_TX;
                           d.m_evt = 1'b0;
                        end
                     end
                     M_RX: begin
                        if (q.m_bit == ACK_SLOT - 4'h1) begin
                           d.con.master_receive_go = 1'b0;
                           if (q.stat.rx_full) begin
                              d.stat.rx_overflow = 1'b1;
                           end else begin
                              d.rx           = q.m_sh;
                              d.stat.rx_full = 1'b1;
                           end
                        end else begin
                           d.m_st  = M_RX;
                           d.m_evt = 1'b0;
                        end
                     end
                     default: d.m_st = M_IDLE;
                  endcase
               end
            endcase
         end

         // Slave side and bus condition tracking
         if (ln.start) begin
            d.stat.start_seen = 1'b1;
            d.stat.stop_seen  = 1'b0;
            d.s_bit           = 4'h0;
            d.s_sda_low       = 1'b0;
            // Our own start sequence must not wake the slave side
            d.s_md            = (q.m_own | (q.m_st != M_IDLE)) ? S_OFF : S_ADDR;
         end else if (ln.stop) begin
            d.stat.stop_seen            = 1'b1;
            d.stat.start_seen           = 1'b0;
            d.stat.broadcast_seen       = 1'b0;
            d.stat.wide_address_matched = 1'b0;
            d.s_md                      = S_OFF;
            d.s_sda_low                 = 1'b0;
         end else if (q.s_md != S_OFF) begin
            if (ln.scl_rise) begin
               if (q.s_bit < ACK_SLOT) begin
                  d.s_bit = q.s_bit + 4'h1;
                  if (q.s_md != S_TX) d.s_sh = {q.s_sh[6:0], ln.sda};
               end else if (q.s_md == S_TX && ln.sda) begin
                  d.s_md = S_OFF;
               end
            end
            if (ln.scl_fall) begin
               if (q.s_bit == ACK_SLOT) begin
                  d.s_bit = ACK_SLOT + 4'h1;
                  unique case (q.s_md)
                     S_ADDR: begin
                        gc = q.con.broadcast_enable & (q.s_sh == 8'h00);
                        if (q.con.wide_address_select) begin
                           hit = q.s_sh[7:3] == WIDE_HDR && q.s_sh[2:1] == q.own[9:8];
                           d.s_md = q.s_sh[0] ? S_TX : S_ADDR2;
                        end else begin
                           hit = q.s_sh[7:1] == q.own[6:0];
                           d.s_md = q.s_sh[0] ? S_TX : S_RX;
                        end
                        hit = hit | gc | q.con.accept_all_addresses;
                        if (gc) begin
                           d.s_md                = S_RX;
                           d.stat.broadcast_seen = 1'b1;
                        end
                        if (hit) begin
                           d.s_sda_low           = 1'b1;
                           d.stat.data_not_addr  = 1'b0;
                           d.stat.read_not_write = q.s_sh[0];
                           d.s_evt               = 1'b1;
                        end else begin
                           d.s_md = S_OFF;
                        end
                     end
                     S_ADDR2: begin
                        if (q.con.accept_all_addresses || q.s_sh == q.own[7:0]) begin
                           d.stat.wide_address_matched = 1'b1;
                           d.stat.data_not_addr        = 1'b0;
                           d.s_sda_low                 = 1'b1;
                           d.s_md                      = S_RX;
                           d.s_evt                     = 1'b1;
                        end else begin
                           d.s_md = S_OFF;
                        end
                     end
                     S_RX: begin
                        d.stat.data_not_addr = 1'b1;
                        d.s_evt              = 1'b1;
                        if (q.stat.rx_full) begin
                           d.stat.rx_overflow = 1'b1;
                        end else begin
                           d.rx           = q.s_sh;
                           d.stat.rx_full = 1'b1;
                           d.s_sda_low    = 1'b1;
                        end
                     end
                     default: begin
                        d.stat.tx_full = 1'b0;
                        d.s_evt        = 1'b1;
                     end
                  endcase
               end else if (q.s_bit > ACK_SLOT) begin
                  d.s_bit     = 4'h0;
                  d.s_sda_low = 1'b0;
                  if (q.s_md == S_TX) begin
                     d.con.clock_release = 1'b0;
                     d.s_sh              = q.tx;
                  end else if (q.s_md == S_RX && q.con.stretch_enable) begin
                     d.con.clock_release = 1'b0;
                  end
               end else if (q.s_md == S_TX) begin
                  d.s_sh = {q.s_sh[6:0], 1'b0};
               end
            end
         end
      end

      // Open-drain pins: enable high pulls the line low
      ssda = (d.s_md == S_TX && d.s_bit <= ACK_SLOT) ? ~d.s_sh[7] : d.s_sda_low;
      d.pin.scl_oe = d.con.module_on
                     & (d.m_scl_low | (d.s_md != S_OFF & ~d.con.clock_release));
      d.pin.sda_oe = d.con.module_on & (d.m_sda_low | (d.s_md != S_OFF & ssda));
      d.pad.pins_owned           = d.con.module_on;
      d.pad.slew_limit_off       = d.con.slew_limit_off;
      d.pad.alt_input_thresholds = d.con.alt_input_thresholds;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q                <= '0;
         q.con            <= CON_RST;
         q.stat           <= STAT_RST;
         q.own            <= OWN_RST;
         q.av.waitrequest <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign o_av           = q.av;
   assign o_pin          = q.pin;
   assign o_pad          = q.pad;
   assign o_master_event = q.m_evt;
   assign o_slave_event  = q.s_evt;

endmodule

/* verif/tw_ctrl_assertions.sv */
`timescale 1ns/1ns
module tw_ctrl_assertions (
   input wire logic          i_clk,
   input wire logic          i_nrst,
   input tw_pkg::tw_av_req_t i_av,
   input tw_pkg::tw_av_rsp_t o_av,
   input tw_pkg::tw_pin_t    o_pin,
   input tw_pkg::tw_pad_t    o_pad,
   input wire logic          o_master_event,
   input wire logic          o_slave_event
);
   import tw_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   AST_WAIT_ONE: assert property ((i_av.read || i_av.write) && o_av.waitrequest |=> !o_av.waitrequest)
      else $error("no answer one cycle after request");
   AST_WAIT_PULSE: assert property (!o_av.waitrequest |=> o_av.waitrequest)
      else $error("waitrequest low for more than one cycle");
   AST_PAD_COPY: assert property (i_av.write && !o_av.waitrequest && i_av.address == A_CON
      |=> ##1 o_pad == {$past(i_av.writedata[15], 2), $past(i_av.writedata[9:8], 2)})
      else $error("pad controls do not follow control write");
   AST_PINS_FREE: assert property (!o_pad.pins_owned && !$past(o_pad.pins_owned)
      |-> !o_pin.scl_oe && !o_pin.sda_oe) else $error("pins driven while module off");
   AST_OPEN_DRAIN: assert property (!o_pin.scl_o && !o_pin.sda_o)
      else $error("pin drives a high level");
   AST_MEV_PULSE: assert property (o_master_event |=> !o_master_event)
      else $error("master event longer than one cycle");
   AST_SEV_PULSE: assert property (o_slave_event |=> !o_slave_event)
      else $error("slave event longer than one cycle");
   AST_UNMAPPED: assert property (i_av.read && o_av.waitrequest && i_av.address > A_OWN
      |=> o_av.readdata == 32'h0000_0000) else $error("unmapped read not zero");
endmodule

bind tw_ctrl tw_ctrl_assertions u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_av(i_av), .o_av(o_av),
   .o_pin(o_pin), .o_pad(o_pad), .o_master_event(o_master_event), .o_slave_event(o_slave_event));

/* verif/tw_bus_peer.sv */
`timescale 1ns/1ns
module tw_bus_peer (
   input  wire logic i_ack,
   input  wire logic i_clash,
   input  wire logic i_slow,
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_scl_pull,
   output logic      o_sda_pull
);
   int   cnt   = 0;
   logic ack_q = 1'b0;
   assign o_sda_pull = i_clash || ack_q;
   // A start or repeated start restarts the bit count
   always @(negedge i_sda) if (i_scl) cnt = 0;
   always @(posedge i_scl) cnt = cnt + 1;
   // Ninth slot of each byte is answered from the fall before it
   always @(negedge i_scl) ack_q <= i_ack && cnt % 9 == 8;
   initial o_scl_pull = 1'b0;
   // Slow mode stretches every low phase
   always @(negedge i_scl) if (i_slow) begin
      o_scl_pull = 1'b1;
      #9000 o_scl_pull = 1'b0;
   end
endmodule

/* verif/tb_tw_ctrl.sv */
`timescale 1ns/1ns
module tb_tw_ctrl;
   import tw_pkg::*;
   logic        i_clk, i_nrst, i_idle_req, ack, clash, slow, scl_pull, sda_pull, mev, sev, mscl, msda;
   logic [17:0] fr, rk;
   int          nsev = 0;
   tw_av_req_t  i_av;
   tw_av_rsp_t  o_av;
   tw_pin_t     o_pin;
   logic [63:0] exp_q[$];
   logic [63:0] e;
   logic [31:0] rs = 32'h0ef5_2903;
   logic [31:0] v;
   int          fails = 0;
   int          num_checks = 0;
   wire         scl = !(o_pin.scl_oe || scl_pull || !mscl);
   wire         sda = !(o_pin.sda_oe || sda_pull || !msda);
   tw_ctrl u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_idle_req(i_idle_req), .i_scl(scl), .i_sda(sda), .i_av(i_av),
      .o_av(o_av), .o_pin(o_pin), .o_pad(), .o_master_event(mev), .o_slave_event(sev));
   tw_bus_peer u_peer (.i_ack(ack), .i_clash(clash), .i_slow(slow), .i_scl(scl), .i_sda(sda),
      .o_scl_pull(scl_pull), .o_sda_pull(sda_pull));
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic give_up;
      fails++;
      print_verdict();
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1);
      int n;
      n = 0;
      if (!w) exp_q.push_back({m, d & m});
      i_av <= '{read: !w, write: w, address: a, writedata: d};
      do begin
         @(posedge i_clk);
         n++;
      end while (o_av.waitrequest !== 1'b0 && n < 50);
      i_av <= '0;
      @(posedge i_clk);
      if (n >= 50) give_up();
   endtask
   task automatic ev;
      int n;
      n = 0;
      while (mev !== 1'b1 && n < 8000) begin
         @(posedge i_clk);
         n++;
      end
      if (n >= 8000) give_up();
      @(posedge i_clk);
   endtask
   task automatic go(input logic [31:0] c);
      bus(1, A_CON, c);
      ev();
      bus(0, A_CON, 32'h0, 32'h001f);
   endtask
   // One bench-mastered bit on the link: 320 ns clock period
   task automatic mbit(input logic b, output logic r);
      mscl <= 0;
      repeat (2) @(posedge i_clk);
      msda <= b;
      repeat (2) @(posedge i_clk);
      mscl <= 1;
      repeat (4) @(posedge i_clk);
      r = sda;
   endtask
   always @(posedge i_clk) if (sev === 1'b1) nsev++;
   always @(posedge i_clk) if (i_av.read && o_av.waitrequest === 1'b0) begin
      e = exp_q.pop_front();
      num_checks++;
      if ((o_av.readdata & e[63:32]) !== e[31:0]) begin
         fails++;
         $display("mismatch readdata at %h expected %h seen %h", i_av.address, e[31:0], o_av.readdata & e[63:32]);
      end
   end
   initial begin
      i_clk = 0;
      forever #20 i_clk = ~i_clk;
   end
   initial begin
      i_nrst = 0; i_idle_req = 0; i_av = '0; ack = 0; clash = 0; slow = 0; mscl = 1; msda = 1;
      repeat (8) @(posedge i_clk);
      i_nrst <= 1;
      repeat (4) @(posedge i_clk);
      bus(0, A_CON, 32'h1000);
      bus(0, A_STAT, 32'h0);
      bus(0, 8'h14, 32'h0);
      v = xs();
      bus(1, A_OWN, v);
      bus(0, A_OWN, v, 32'h03ff);
      bus(1, A_CON, 32'h8000);
      bus(0, A_CON, 32'h9000);
      bus(1, A_CON, 32'h9340);
      bus(1, A_CON, 32'h8340);
      bus(0, A_CON, 32'h8340);
      v = xs() & 32'h0f80;
      bus(1, A_CON, 32'h9000 | v);
      bus(0, A_CON, 32'h9000 | v);
      i_idle_req <= 1;
      bus(1, A_CON, 32'ha001);
      repeat (400) @(posedge i_clk);
      bus(0, A_CON, 32'hb001);
      i_idle_req <= 0;
      ev();
      bus(0, A_STAT, 32'h8, 32'h18);
      ack <= 1;
      slow <= 1;
      bus(1, A_TX, 32'ha4);
      bus(0, A_STAT, 32'h4001, 32'h4001);
      bus(1, A_TX, 32'h55);
      ev();
      bus(0, A_STAT, 32'h80, 32'hc081);
      bus(1, A_STAT, 32'hff7f);
      bus(0, A_STAT, 32'h0, 32'h80);
      slow <= 0;
      ack <= 0;
      go(32'h9002);
      bus(1, A_TX, 32'ha5);
      ev();
      bus(0, A_STAT, 32'h8000, 32'h8000);
      go(32'h9008);
      bus(0, A_RX, 32'hff);
      bus(0, A_STAT, 32'h0, 32'h2);
      go(32'h9030);
      bus(0, A_CON, 32'h20, 32'h3f);
      go(32'h9004);
      bus(0, A_STAT, 32'h10, 32'h18);
      go(32'h9001);
      clash <= 1;
      bus(1, A_TX, 32'hff);
      ev();
      bus(0, A_STAT, 32'h400, 32'h400);
      bus(0, A_CON, 32'h0, 32'h1f);
      clash <= 0;
      bus(1, A_STAT, 32'hfbff);
      bus(0, A_STAT, 32'h0, 32'h400);
      // Slave receive: address 7'h52 write, then one random data byte
      bus(1, A_OWN, 32'h52);
      v = xs();
      fr = {8'ha4, 1'b1, v[7:0], 1'b1};
      msda <= 0;
      repeat (4) @(posedge i_clk);
      for (int i = 17; i >= 0; i--) mbit(fr[i], rk[i]);
      mscl <= 0;
      repeat (2) @(posedge i_clk);
      msda <= 0;
      repeat (2) @(posedge i_clk);
      mscl <= 1;
      repeat (4) @(posedge i_clk);
      msda <= 1;
      repeat (4) @(posedge i_clk);
      num_checks++;
      if (rk[9] !== 1'b0 || rk[0] !== 1'b0) begin
         fails++;
         $display("mismatch slave ack expected 00 seen %b%b", rk[9], rk[0]);
      end
      num_checks++;
      if (nsev !== 2) begin
         fails++;
         $display("mismatch slave events expected 2 seen %0d", nsev);
      end
      bus(0, A_STAT, 32'h32, 32'h3e);
      bus(0, A_RX, v & 32'hff);
      print_verdict();
   end
endmodule
